// ---- hw/led_pkg.sv ----
// Shared constants and types for the status indicator sequencer.
package led_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_OVR_EN  = 12'h004;
	localparam logic [11:0] OFS_OVR_PAT = 12'h008;
	localparam logic [11:0] OFS_STATUS  = 12'h00C;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CTRL_USB_CFG   = 0;
	localparam int CTRL_CFG_FAULT = 1;
	localparam int CTRL_SUP_FAULT = 2;
	localparam int CTRL_FW_UPDATE = 3;
	localparam int CTRL_DEV_ERROR = 4;
	localparam int CTRL_RUN       = 5;
	localparam int CTRL_W         = 6;
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam int PAT_W          = 4;   // Pattern code in [2:0], colour swap in [3].
	localparam int PAT_SWAP       = 3;
	localparam int STAT_OVR_POS   = 16;
	localparam int MAX_CH         = 7;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 5;
	localparam int FLASH_TIME_US  = 20;
	localparam int SLOW_HALF_MS   = 500;
	localparam int FAST_HALF_MS   = 100;
	localparam int FLASH_CYC = (FLASH_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOW_CYC  = (SLOW_HALF_MS * 1000000) / CLK_PERIOD_NS;
	localparam int FAST_CYC  = (FAST_HALF_MS * 1000000) / CLK_PERIOD_NS;

	// Light patterns; the first colour is the one a blink lights.
	typedef enum logic [2:0] {
		PAT_OFF,
		PAT_ON,
		PAT_SLOW_BLINK,
		PAT_FAST_BLINK,
		PAT_SLOW_WAVER,
		PAT_FAST_WAVER,
		PAT_FLASH
	} pat_e;

endpackage

// ---- hw/tick_if.sv ----
// Blink phase signals passed from the timebase to the sequencer.
`timescale 1ns/1ps
interface tick_if;
	logic slow_ph;
	logic fast_ph;
	logic slow_tick;
	modport src (output slow_ph, output fast_ph, output slow_tick);
	modport snk (input slow_ph, input fast_ph, input slow_tick);
endinterface

// ---- hw/blink_timebase.sv ----
// Prescaler that makes the slow and fast blink phases.
`timescale 1ns/1ps
module blink_timebase #(
	parameter int SLOW_CYC = led_pkg::SLOW_CYC,
	parameter int FAST_CYC = led_pkg::FAST_CYC
) (
	input  wire logic hclk,    // System clock.
	input  wire logic hresetn, // Asynchronous reset, active low.
	tick_if.src       tk       // Phase outputs.
);
	localparam int SW = $clog2(SLOW_CYC);
	localparam int FW = $clog2(FAST_CYC);
	localparam logic [SW-1:0] SLOW_LAST = SW'(SLOW_CYC - 1);
	localparam logic [FW-1:0] FAST_LAST = FW'(FAST_CYC - 1);

	// A fast blink that is not faster than the slow one is meaningless.
	if (FAST_CYC < 2 || SLOW_CYC <= FAST_CYC) begin : g_chk
		$error("blink_timebase: need 2 <= FAST_CYC < SLOW_CYC");
	end

	logic [SW-1:0] slow_cnt_q;
	logic [FW-1:0] fast_cnt_q;

	// ------------------------------------------------------------
	// Slow half-period counter
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slow_cnt_q   <= '0;
			tk.slow_ph   <= 1'b0;
			tk.slow_tick <= 1'b0;
		end else if (slow_cnt_q == SLOW_LAST) begin
			slow_cnt_q   <= '0; // RQ19
			tk.slow_ph   <= ~tk.slow_ph; // RQ5
			tk.slow_tick <= 1'b1;
		end else begin
			slow_cnt_q   <= slow_cnt_q + 1'b1;
			tk.slow_tick <= 1'b0;
		end
	end

	// Fast half-period counter; equal on and off halves by toggling.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_cnt_q <= '0;
			tk.fast_ph <= 1'b0;
		end else if (fast_cnt_q == FAST_LAST) begin
			fast_cnt_q <= '0; // RQ19
			tk.fast_ph <= ~tk.fast_ph; // RQ6
		end else begin
			fast_cnt_q <= fast_cnt_q + 1'b1;
		end
	end

endmodule

// ---- hw/status_led_sequencer.sv ----
// Indicator sequencer: AHB-Lite registers, pattern selection, lamp drive.
// How it works
// (RQ1) Supply lamp green/yellow, traffic lamp yellow/red.
// (RQ2) One traffic lamp per channel, own state.
// (RQ3) Device error lights all traffic reds.
// (RQ4) Flash is short pulse; repeats merge.
// (RQ5) Slow blink: equal on and off halves.
// (RQ6) Fast blink: equal halves, faster than slow.
// (RQ7) Slow waver: second colour in dark half.
// (RQ8) Fast waver: colours alternate at fast rate.
// (RQ9) Running: one colour lit, stepping in order.
// (RQ10) Configured and healthy: supply lamp steady green.
// (RQ11) Unconfigured: supply slow blinks yellow, traffic dark.
// (RQ12) Config fault: all lamps slow waver.
// (RQ13) Supply fault: supply wavers, traffic blinks yellow.
// (RQ14) Idle dark; frame yellow flash; error red.
// (RQ15) Error-passive: traffic fast blinks red.
// (RQ16) Firmware update: all traffic fast blink yellow.
// (RQ17) Overrun: steady red until bus-off.
// (RQ18) No user indication unless user overrides.
// (RQ19) Timings come from parameterised prescaler counts.
// (RQ20) Priority: update, overrun, passive, then flashes.
`timescale 1ns/1ps
module status_led_sequencer #(
	parameter int NCH       = 1,                   // Bus channels.
	parameter int FLASH_CYC = led_pkg::FLASH_CYC,  // Flash pulse cycles.
	parameter int SLOW_CYC  = led_pkg::SLOW_CYC,   // Slow half period cycles.
	parameter int FAST_CYC  = led_pkg::FAST_CYC    // Fast half period cycles.
) (
	input  wire logic           hclk,          // Clock, 200 MHz.
	input  wire logic           hresetn,       // Asynchronous reset, active low.
	input  wire logic           hsel,          // Slave select.
	input  wire logic [31:0]    haddr,         // Byte address.
	input  wire logic [1:0]     htrans,        // Transfer type.
	input  wire logic           hwrite,        // Write when high.
	input  wire logic [2:0]     hsize,         // Transfer size.
	input  wire logic [31:0]    hwdata,        // Write data.
	input  wire logic           hready,        // Bus ready.
	output logic                hreadyout,     // Always ready.
	output logic                hresp,         // Always OKAY.
	output logic [31:0]         hrdata,        // Read data.
	input  wire logic [NCH-1:0] frame_evt,     // Frame sent or received, pulse.
	input  wire logic [NCH-1:0] err_frame_evt, // Error frame received, pulse.
	input  wire logic [NCH-1:0] err_passive,   // Controller error-passive, level.
	input  wire logic [NCH-1:0] overrun_evt,   // Receive overrun, pulse.
	input  wire logic [NCH-1:0] bus_off,       // Controller bus-off, level.
	output logic                sup_green,     // Supply lamp green.
	output logic                sup_yellow,    // Supply lamp yellow.
	output logic [NCH-1:0]      trf_yellow,    // Traffic lamps yellow.
	output logic [NCH-1:0]      trf_red        // Traffic lamps red.
);
	localparam int FW  = $clog2(FLASH_CYC + 1);
	localparam int NL  = NCH + 1;
	localparam logic [FW-1:0] FLASH_LOAD = FW'(FLASH_CYC);
	localparam logic [3:0] RUN_LAST = 4'(2 * NCH + 1);

	// Override nibbles must fit the one pattern register.
	if (NCH < 1 || NCH > led_pkg::MAX_CH || FLASH_CYC < 1) begin : g_chk
		$error("status_led_sequencer: NCH must be 1..7, FLASH_CYC >= 1");
	end

	tick_if tk ();

	blink_timebase #(
		.SLOW_CYC (SLOW_CYC),
		.FAST_CYC (FAST_CYC)
	) u_tb (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tk      (tk)
	);

	// ------------------------------------------------------------
	// Pattern rendering
	// ------------------------------------------------------------
	// Returns {first colour, second colour}; swap exchanges them.
	function automatic logic [1:0] show(led_pkg::pat_e p, logic swap, logic fl);
		logic [1:0] c;
		c = 2'h0;
		case (p)
			led_pkg::PAT_ON:         c = 2'h2;
			led_pkg::PAT_SLOW_BLINK: c = {tk.slow_ph, 1'b0}; // RQ5
			led_pkg::PAT_FAST_BLINK: c = {tk.fast_ph, 1'b0}; // RQ6
			led_pkg::PAT_SLOW_WAVER: c = {tk.slow_ph, ~tk.slow_ph}; // RQ7
			led_pkg::PAT_FAST_WAVER: c = {tk.fast_ph, ~tk.fast_ph}; // RQ8
			led_pkg::PAT_FLASH:      c = {fl, 1'b0}; // RQ4
			default:                 c = 2'h0;
		endcase
		return swap ? {c[0], c[1]} : c;
	endfunction

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	logic [led_pkg::CTRL_W-1:0] ctrl_q;
	logic [led_pkg::CTRL_W-1:0] ctrl_d;
	logic [NL-1:0]              ovr_en_q;
	logic [NL-1:0]              ovr_en_d;
	logic [NL*4-1:0]            ovr_pat_q;
	logic [NL*4-1:0]            ovr_pat_d;
	logic                       wr_pend_q;
	logic [11:0]                waddr_q;
	logic [NCH-1:0]             ovrl_q;
	logic [31:0]                rd_word;

	// Address phase is taken on hready; a write lands in its data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			waddr_q   <= 12'h000;
		end else if (hready) begin
			wr_pend_q <= hsel && htrans[1] && hwrite && haddr[31:12] == 20'h00000;
			waddr_q   <= haddr[11:0];
		end
	end

	// Next register values; reads see them so a write is visible at once.
	always_comb begin
		ctrl_d    = ctrl_q;
		ovr_en_d  = ovr_en_q;
		ovr_pat_d = ovr_pat_q;
		if (wr_pend_q && hready) begin
			if (waddr_q == led_pkg::OFS_CTRL) begin
				ctrl_d = hwdata[led_pkg::CTRL_W-1:0];
			end else if (waddr_q == led_pkg::OFS_OVR_EN) begin
				ovr_en_d = hwdata[NL-1:0];
			end else if (waddr_q == led_pkg::OFS_OVR_PAT) begin
				ovr_pat_d = hwdata[NL*4-1:0];
			end
		end
	end

	// Read decode; unmapped addresses read zero and never stall.
	always_comb begin
		rd_word = 32'h0000_0000;
		if (haddr[31:12] != 20'h00000) begin
			rd_word = 32'h0000_0000;
		end else if (haddr[11:0] == led_pkg::OFS_CTRL) begin
			rd_word[led_pkg::CTRL_W-1:0] = ctrl_d;
		end else if (haddr[11:0] == led_pkg::OFS_OVR_EN) begin
			rd_word[NL-1:0] = ovr_en_d;
		end else if (haddr[11:0] == led_pkg::OFS_OVR_PAT) begin
			rd_word[NL*4-1:0] = ovr_pat_d;
		end else if (haddr[11:0] == led_pkg::OFS_STATUS) begin
			rd_word[0] = sup_green;
			rd_word[1] = sup_yellow;
			for (int i = 0; i < NCH; i++) begin
				rd_word[2 + 2 * i] = trf_yellow[i];
				rd_word[3 + 2 * i] = trf_red[i];
			end
			rd_word[led_pkg::STAT_OVR_POS +: NCH] = ovrl_q;
		end
	end

	// Registers and bus answer.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q    <= led_pkg::CTRL_RST;
			ovr_en_q  <= '0; // RQ18
			ovr_pat_q <= '0;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			ovr_en_q  <= ovr_en_d;
			ovr_pat_q <= ovr_pat_d;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite) begin
				hrdata <= rd_word;
			end
		end
	end

	// ------------------------------------------------------------
	// Channel state
	// ------------------------------------------------------------
	logic [FW-1:0] fly_q [NCH];
	logic [FW-1:0] frd_q [NCH];

	// Flash stretchers; a new event reloads, so bursts merge into steady light.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NCH; i++) begin
				fly_q[i] <= '0;
				frd_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (frame_evt[i]) begin
					fly_q[i] <= FLASH_LOAD; // RQ4
				end else if (fly_q[i] != '0) begin
					fly_q[i] <= fly_q[i] - 1'b1;
				end
				if (err_frame_evt[i]) begin
					frd_q[i] <= FLASH_LOAD; // RQ4
				end else if (frd_q[i] != '0) begin
					frd_q[i] <= frd_q[i] - 1'b1;
				end
			end
		end
	end

	// Overrun latch; a new overrun in the bus-off cycle still sets it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovrl_q <= '0;
		end else begin
			ovrl_q <= (ovrl_q & ~bus_off) | overrun_evt; // RQ17
		end
	end

	// Running step index, restarted whenever running mode is left.
	logic [3:0] run_idx_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_idx_q <= 4'h0;
		end else if (!ctrl_q[led_pkg::CTRL_RUN]) begin
			run_idx_q <= 4'h0;
		end else if (tk.slow_tick) begin
			run_idx_q <= (run_idx_q == RUN_LAST) ? 4'h0 : run_idx_q + 4'h1; // RQ9
		end
	end

	// ------------------------------------------------------------
	// Pattern selection
	// ------------------------------------------------------------
	logic [1:0]     sup_c;
	logic [1:0]     trf_c [NCH];
	logic [NCH-1:0] tr_norm;
	logic [NCH-1:0] tr_pass;
	logic           run;

	// Supply lamp: first colour green, second yellow.
	always_comb begin
		run = ctrl_q[led_pkg::CTRL_RUN];
		if (ovr_en_q[0]) begin
			sup_c = show(led_pkg::pat_e'(ovr_pat_q[2:0]), ovr_pat_q[3], 1'b1); // RQ18
		end else if (run) begin
			sup_c = {run_idx_q == 4'h0, run_idx_q == 4'h1}; // RQ9
		end else if (ctrl_q[led_pkg::CTRL_CFG_FAULT]) begin
			sup_c = show(led_pkg::PAT_SLOW_WAVER, 1'b0, 1'b0); // RQ12
		end else if (ctrl_q[led_pkg::CTRL_SUP_FAULT]) begin
			sup_c = show(led_pkg::PAT_SLOW_WAVER, 1'b0, 1'b0); // RQ13
		end else if (!ctrl_q[led_pkg::CTRL_USB_CFG]) begin
			sup_c = show(led_pkg::PAT_SLOW_BLINK, 1'b1, 1'b0); // RQ11
		end else begin
			sup_c = show(led_pkg::PAT_ON, 1'b0, 1'b0); // RQ10
		end
	end

	// Traffic lamps: first colour yellow, second red; each sees its own channel.
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			tr_norm[i] = 1'b0;
			tr_pass[i] = 1'b0;
			if (ovr_en_q[i + 1]) begin
				trf_c[i] = show(led_pkg::pat_e'(ovr_pat_q[4 * i + 4 +: 3]),
					ovr_pat_q[4 * i + 4 + led_pkg::PAT_SWAP], 1'b1); // RQ18
			end else if (run) begin
				trf_c[i] = {run_idx_q == 4'(2 + 2 * i), run_idx_q == 4'(3 + 2 * i)}; // RQ9
			end else if (ctrl_q[led_pkg::CTRL_DEV_ERROR]) begin
				trf_c[i] = show(led_pkg::PAT_ON, 1'b1, 1'b0); // RQ3
			end else if (ctrl_q[led_pkg::CTRL_CFG_FAULT]) begin
				trf_c[i] = show(led_pkg::PAT_SLOW_WAVER, 1'b0, 1'b0); // RQ12
			end else if (ctrl_q[led_pkg::CTRL_SUP_FAULT]) begin
				trf_c[i] = show(led_pkg::PAT_SLOW_BLINK, 1'b0, 1'b0); // RQ13
			end else if (!ctrl_q[led_pkg::CTRL_USB_CFG]) begin
				trf_c[i] = 2'h0; // RQ11
			end else if (ctrl_q[led_pkg::CTRL_FW_UPDATE]) begin
				trf_c[i] = show(led_pkg::PAT_FAST_BLINK, 1'b0, 1'b0); // RQ16
			end else if (ovrl_q[i]) begin
				trf_c[i] = show(led_pkg::PAT_ON, 1'b1, 1'b0); // RQ20
			end else if (err_passive[i]) begin
				tr_pass[i] = 1'b1;
				trf_c[i] = show(led_pkg::PAT_FAST_BLINK, 1'b1, 1'b0); // RQ15
			end else begin
				tr_norm[i] = 1'b1;
				if (frd_q[i] != '0) begin
					trf_c[i] = show(led_pkg::PAT_FLASH, 1'b1, 1'b1); // RQ14
				end else begin
					trf_c[i] = show(led_pkg::PAT_FLASH, 1'b0, fly_q[i] != '0); // RQ14
				end
			end
		end
	end

	// Lamp drive flops; every output comes straight from a register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sup_green  <= 1'b0;
			sup_yellow <= 1'b0;
			trf_yellow <= '0;
			trf_red    <= '0;
		end else begin
			sup_green  <= sup_c[1]; // RQ1
			sup_yellow <= sup_c[0];
			for (int i = 0; i < NCH; i++) begin
				trf_yellow[i] <= trf_c[i][1]; // RQ2
				trf_red[i]    <= trf_c[i][0];
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	logic plain;
	assign plain = ~|ovr_en_q && !run;

	property p_dev_err;
		@(posedge hclk) disable iff (!hresetn)
		plain && ctrl_q[led_pkg::CTRL_DEV_ERROR] |=> &trf_red && ~|trf_yellow;
	endproperty
	a_dev_err: assert property (p_dev_err) else $error("device error not all red"); // RQ3

	property p_ok_green;
		@(posedge hclk) disable iff (!hresetn)
		plain && ctrl_q[2:0] == 3'h1 |=> sup_green && !sup_yellow;
	endproperty
	a_ok_green: assert property (p_ok_green) else $error("supply lamp not green"); // RQ10

	property p_wait_cfg;
		@(posedge hclk) disable iff (!hresetn)
		plain && ctrl_q[led_pkg::CTRL_DEV_ERROR:0] == 5'h00
		|=> !sup_green && sup_yellow == $past(tk.slow_ph) && ~|{trf_yellow, trf_red};
	endproperty
	a_wait_cfg: assert property (p_wait_cfg) else $error("unconfigured pattern wrong"); // RQ11

	property p_ovr_set;
		@(posedge hclk) disable iff (!hresetn)
		overrun_evt[0] |=> ovrl_q[0];
	endproperty
	a_ovr_set: assert property (p_ovr_set) else $error("overrun lost"); // RQ17

	property p_ovr_hold;
		@(posedge hclk) disable iff (!hresetn)
		ovrl_q[0] && !bus_off[0] |=> ovrl_q[0];
	endproperty
	a_ovr_hold: assert property (p_ovr_hold) else $error("overrun cleared early"); // RQ17

	property p_flash_len;
		@(posedge hclk) disable iff (!hresetn)
		frame_evt[0] ##1 !frame_evt[0] |=> fly_q[0] == FLASH_LOAD - 1'b1;
	endproperty
	a_flash_len: assert property (p_flash_len) else $error("flash length wrong"); // RQ4

	property p_act;
		@(posedge hclk) disable iff (!hresetn)
		frame_evt[0] && tr_norm[0] ##1 tr_norm[0] && frd_q[0] == '0 |=> trf_yellow[0];
	endproperty
	a_act: assert property (p_act) else $error("activity flash missing"); // RQ14

	property p_passive;
		@(posedge hclk) disable iff (!hresetn)
		tr_pass[0] |=> trf_red[0] == $past(tk.fast_ph) && !trf_yellow[0];
	endproperty
	a_passive: assert property (p_passive) else $error("passive blink wrong"); // RQ15

	property p_run_one;
		@(posedge hclk) disable iff (!hresetn)
		~|ovr_en_q && run |=> $onehot({sup_green, sup_yellow, trf_yellow, trf_red});
	endproperty
	a_run_one: assert property (p_run_one) else $error("running lights not one-hot"); // RQ9

	c_run_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
		run_idx_q == RUN_LAST ##1 run_idx_q == 4'h0);
	c_ovr_off: cover property (@(posedge hclk) disable iff (!hresetn)
		ovrl_q[0] ##1 !ovrl_q[0]);
	c_merge: cover property (@(posedge hclk) disable iff (!hresetn)
		frame_evt[0] && fly_q[0] != '0);

endmodule

// ---- bench/lamp_watch.sv ----
// Model of one dual-colour lamp as a watcher sees it: lit time and turn-ons.
`timescale 1ns/1ps
module lamp_watch (
	input  wire logic hclk,  // Clock.
	input  wire logic clr,   // Restart all counts.
	input  wire logic c1,    // First colour lit.
	input  wire logic c2,    // Second colour lit.
	output int        n1,    // Cycles first colour lit.
	output int        n2,    // Cycles second colour lit.
	output int        nboth, // Cycles both colours lit.
	output int        r1,    // Turn-ons of first colour.
	output int        r2     // Turn-ons of second colour.
);
	logic p1_q;
	logic p2_q;

	// ------------------------------------------------------------
	// Counting
	// ------------------------------------------------------------
	// A lamp shows one colour at a time, so both lit together is counted apart.
	always @(posedge hclk) begin
		if (clr) begin
			n1 <= 0;
			n2 <= 0;
			nboth <= 0;
			r1 <= 0;
			r2 <= 0;
		end else begin
			n1 <= n1 + int'(c1);
			n2 <= n2 + int'(c2);
			nboth <= nboth + int'(c1 & c2);
			r1 <= r1 + int'(c1 & ~p1_q);
			r2 <= r2 + int'(c2 & ~p2_q);
		end
		p1_q <= c1;
		p2_q <= c2;
	end
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the status indicator sequencer.
`timescale 1ns/1ps
module tb;
	localparam int NCH = 2;
	logic           hclk = 1'b0;
	logic           hresetn = 1'b0;
	logic           hsel = 1'b0;
	logic [31:0]    haddr = 32'h0;
	logic [1:0]     htrans = 2'h0;
	logic           hwrite = 1'b0;
	logic [2:0]     hsize = 3'h2;
	logic [31:0]    hwdata = 32'h0;
	wire logic      hready;
	logic           hresp;
	logic [31:0]    hrdata;
	logic [NCH-1:0] frame_evt = '0;
	logic [NCH-1:0] err_frame_evt = '0;
	logic [NCH-1:0] err_passive = '0;
	logic [NCH-1:0] overrun_evt = '0;
	logic [NCH-1:0] bus_off = '0;
	logic           sup_green;
	logic           sup_yellow;
	logic [NCH-1:0] trf_yellow;
	logic [NCH-1:0] trf_red;
	logic           clr = 1'b1;
	int             err_count = 0;
	int             checks_done = 0;
	integer         seed = 28;
	int             n1[3];
	int             n2[3];
	int             nb[3];
	int             r1[3];
	int             r2[3];
	wire logic [2:0] c1v = {trf_yellow, sup_green};
	wire logic [2:0] c2v = {trf_red, sup_yellow};
	wire logic [5:0] lamps = {trf_red[1], trf_yellow[1], trf_red[0], trf_yellow[0], sup_yellow,
		sup_green};

	always #2.5 hclk = ~hclk;

	// Short counts keep every blink period inside a 64-cycle window.
	status_led_sequencer #(.NCH(NCH), .FLASH_CYC(4), .SLOW_CYC(16), .FAST_CYC(4)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .frame_evt(frame_evt),
		.err_frame_evt(err_frame_evt), .err_passive(err_passive), .overrun_evt(overrun_evt),
		.bus_off(bus_off), .sup_green(sup_green), .sup_yellow(sup_yellow),
		.trf_yellow(trf_yellow), .trf_red(trf_red));

	// Watcher 0 is the supply lamp, 1 and 2 the traffic lamps.
	for (genvar i = 0; i < 3; i++) begin : g_w
		lamp_watch w (.hclk(hclk), .clr(clr), .c1(c1v[i]), .c2(c2v[i]), .n1(n1[i]),
			.n2(n2[i]), .nboth(nb[i]), .r1(r1[i]), .r2(r2[i]));
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask

	task stop_test;
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One single word transfer; the wait loops trust only the watchdog.
	task ahb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask

	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] x;
		ahb(1'b0, a, 32'h0, x);
		chk(x, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask

	// Lit counts over 64 cycles: supply g/y, traffic 0 y/r, traffic 1 y/r.
	task win(input logic [47:0] e);
		@(posedge hclk);
		clr <= 1'b1;
		@(posedge hclk);
		clr <= 1'b0;
		repeat (64) @(posedge hclk);
		#1;
		for (int i = 0; i < 3; i++) begin
			chk(32'(n1[i]), {24'h0, e[47-16*i -: 8]});
			chk(32'(n2[i]), {24'h0, e[39-16*i -: 8]});
			chk(32'(nb[i]), 32'h0);
		end
	endtask

	// Expected first and second colour counts for an override pattern code.
	function automatic logic [15:0] ovr(input logic [3:0] c);
		logic [15:0] v;
		case (c[2:0])
			3'h1, 3'h6: v = 16'h4000;
			3'h2, 3'h3: v = 16'h2000;
			3'h4, 3'h5: v = 16'h2020;
			default: v = 16'h0000;
		endcase
		return c[3] ? {v[7:0], v[15:8]} : v;
	endfunction

	initial begin
		repeat (30000) @(posedge hclk);
		err_count++;
		stop_test;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [15:0] x;
		logic [5:0]  e;
		int          g;
		int          last;
		logic        p;
		repeat (16) @(posedge hclk);
		chk({26'h0, lamps}, 32'h0);
		hresetn <= 1'b1;
		rdchk(led_pkg::OFS_CTRL, 32'h0);
		rdchk(led_pkg::OFS_OVR_EN, 32'h0);
		rdchk(led_pkg::OFS_OVR_PAT, 32'h0);
		win(48'h0020_0000_0000);
		chk(32'(r2[0] <= 3), 32'h1);
		wr(12'h010, 32'h0000_00FF);
		rdchk(12'h010, 32'h0);
		wr(led_pkg::OFS_CTRL, 32'hFFFF_FFC1);
		rdchk(led_pkg::OFS_CTRL, 32'h1);
		win(48'h4000_0000_0000);
		// One frame on channel 0 and one error frame on channel 1.
		@(posedge hclk);
		clr <= 1'b1;
		frame_evt <= 2'h1;
		err_frame_evt <= 2'h2;
		@(posedge hclk);
		clr <= 1'b0;
		frame_evt <= 2'h0;
		err_frame_evt <= 2'h0;
		repeat (20) @(posedge hclk);
		#1;
		chk(32'(n1[1]), 32'h4);
		chk(32'(n2[1] + n1[2]), 32'h0);
		chk(32'(n2[2]), 32'h4);
		// Random frame bursts, gaps never above three cycles, must merge.
		@(posedge hclk);
		clr <= 1'b1;
		last = 0;
		for (int k = 0; k < 20; k++) begin
			p = (k == 0) || (k - last == 3) || ($random(seed) % 2 != 0);
			if (p)
				last = k;
			frame_evt <= {1'b0, p};
			@(posedge hclk);
			clr <= 1'b0;
		end
		frame_evt <= 2'h0;
		repeat (8) @(posedge hclk);
		#1;
		chk(32'(n1[1]), 32'(last + 4));
		chk(32'(r1[1]), 32'h1);
		// Error-passive must hide the frame flashes.
		err_passive <= 2'h1;
		frame_evt <= 2'h1;
		win(48'h4000_0020_0000);
		chk(32'(r2[1] >= 7), 32'h1);
		frame_evt <= 2'h0;
		overrun_evt <= 2'h1;
		@(posedge hclk);
		overrun_evt <= 2'h0;
		win(48'h4000_0040_0000);
		rdchk(led_pkg::OFS_STATUS, 32'h0001_0009);
		bus_off <= 2'h1;
		repeat (3) @(posedge hclk);
		bus_off <= 2'h0;
		err_passive <= 2'h0;
		win(48'h4000_0000_0000);
		rdchk(led_pkg::OFS_STATUS, 32'h1);
		// A pending overrun on channel 1 stays hidden under the update.
		overrun_evt <= 2'h2;
		@(posedge hclk);
		overrun_evt <= 2'h0;
		wr(led_pkg::OFS_CTRL, 32'h9);
		win(48'h4000_2000_2000);
		chk(32'(r1[1] >= 7), 32'h1);
		repeat (24) begin
			@(posedge hclk);
			#1;
			chk(32'(trf_yellow[0]), 32'(trf_yellow[1]));
		end
		wr(led_pkg::OFS_CTRL, 32'h11);
		win(48'h4000_0040_0040);
		wr(led_pkg::OFS_CTRL, 32'h3);
		win(48'h2020_2020_2020);
		wr(led_pkg::OFS_CTRL, 32'h5);
		win(48'h2020_2000_2000);
		// Sample mid-step, after two step changes, so ticks never race the sample.
		wr(led_pkg::OFS_CTRL, 32'h21);
		repeat (2) begin
			e = lamps;
			g = 0;
			while (lamps === e && g < 40) begin
				@(posedge hclk);
				g++;
			end
		end
		repeat (8) @(posedge hclk);
		#1;
		e = lamps;
		chk(32'($countones(e)), 32'h1);
		repeat (11) begin
			repeat (16) @(posedge hclk);
			#1;
			e = {e[4:0], e[5]};
			chk({26'h0, lamps}, {26'h0, e});
		end
		// Every pattern code, plain and swapped, on the supply lamp and traffic 1.
		wr(led_pkg::OFS_CTRL, 32'h1);
		wr(led_pkg::OFS_OVR_EN, 32'h5);
		for (int c = 0; c < 16; c++) begin
			wr(led_pkg::OFS_OVR_PAT, {20'h0, c[3:0], 4'h0, c[3:0]});
			x = ovr(c[3:0]);
			win({x, 16'h0, x});
		end
		stop_test;
	end
endmodule
